// file: design/mcs_core.sv
// core sequencer: fetch, decode, program stack and interrupt entry
module mcs_core #(
	parameter int IRQ_CYCLES = mcs_pkg::IRQ_CYC
) (
	input  wire logic                     clk,
	input  wire logic                     reset,
	output wire logic [mcs_pkg::PC_W-1:0] rom_addr,
	input  wire logic [7:0]               rom_data,
	output wire logic [7:0]               ram_addr,
	output wire logic [7:0]               ram_wdata,
	output wire logic                     ram_we,
	input  wire logic [7:0]               ram_rdata,
	output wire logic [7:0]               io_addr,
	output wire logic [7:0]               io_wdata,
	output wire logic                     io_we,
	output wire logic                     io_re,
	input  wire logic [7:0]               io_rdata,
	input  wire logic                     irq_req,
	input  wire logic [3:0]               irq_vec,
	output wire logic                     irq_ack,
	output wire logic                     int_enable,
	output wire logic                     halted,
	output wire logic                     rom_reserved
);
	import mcs_pkg::*;

	if (IRQ_CYCLES < 3 || IRQ_CYCLES > 15) begin : g_chk
		$error("IRQ_CYCLES must lie in 3..15");
	end

	mcs_state_t  st_ff;
	logic [13:0] pc_ff, lk_addr_ff;
	logic [7:0]  a_ff, x_ff, psp_ff, dsp_ff, ir_ff, opnd_ff, tmp_ff;
	logic [7:0]  ram_addr_ff, ram_wdata_ff, io_addr_ff, io_wdata_ff;
	logic [3:0]  cyc_ff, vec_ff;
	logic        c_ff, z_ff, ie_ff, lk_ff, ram_we_ff, io_we_ff, io_re_ff, irq_ack_ff, rsv_ff;

	// ---------------------------------------------------------------
	// decode
	// ---------------------------------------------------------------
	wire logic [7:0]  op       = ir_ff;
	wire logic        op_x     = is_idx(op);
	wire logic        op_d     = is_dir(op);
	wire logic        op_i     = is_imm(op);
	wire logic        is_call  = op[7:4] == NB_CALL0 || op[7:4] == NB_CALL1;
	wire logic        two_byte = op_i | op_d | op_x | op[7] | is_call;
	wire logic [7:0]  ea       = rom_data + (op_x ? x_ff : 8'h00);
	wire logic [13:0] br_tgt   = {2'b00, op[3:0], rom_data};
	wire logic [13:0] call_tgt = {2'b00, op[3:0], opnd_ff};
	wire logic [13:0] acc_tgt  = br_tgt + {6'h00, a_ff};
	wire logic [3:0]  ncyc     = op_cycles(op);
	wire logic        last     = cyc_ff == ncyc - 4'h1;
	wire logic        run1     = st_ff == ST_RUN && cyc_ff == 4'h1;
	wire logic        irq_ok   = irq_req && ie_ff && irq_vec <= IRQ_LAST && irq_vec != IRQ_RSVD;
	wire logic        irq_take = st_ff == ST_RUN && cyc_ff == 4'h0 && irq_ok;
	wire logic [7:0]  opm1     = op - 8'h01;
	wire logic [2:0]  fn       = 3'(opm1 / 8'h03);
	wire logic        is_cmp   = fn == 3'h7;
	wire logic [7:0]  alu_b    = (cyc_ff == 4'h1) ? rom_data : ram_rdata;
	wire logic        br_ok    = op[7:4] == NB_JMP || (op[7:4] == NB_JZ && z_ff) || (op[7:4] == NB_JNZ && !z_ff)
		|| (op[7:4] == NB_JC && c_ff) || (op[7:4] == NB_JNC && !c_ff);
	wire logic [8:0]  a_inc    = {1'b0, a_ff} + 9'h001;
	wire logic [8:0]  a_dec    = {1'b0, a_ff} - 9'h001;
	wire logic [8:0]  m_inc    = {1'b0, ram_rdata} + 9'h001;
	wire logic [8:0]  m_dec    = {1'b0, ram_rdata} - 9'h001;
	wire logic [7:0]  rmw_val  = (op == OP_OR_D || op == OP_OR_X) ? (a_ff | ram_rdata) :
		((op == OP_AND_D || op == OP_AND_X) ? (a_ff & ram_rdata) : (a_ff ^ ram_rdata));
	logic [8:0] alu_r;

	always_comb begin
		case (fn)
			3'h0:    alu_r = {1'b0, a_ff} + {1'b0, alu_b};
			3'h1:    alu_r = {1'b0, a_ff} + {1'b0, alu_b} + {8'h00, c_ff};
			3'h3:    alu_r = {1'b0, a_ff} - {1'b0, alu_b} - {8'h00, c_ff};
			3'h4:    alu_r = {1'b0, a_ff | alu_b};
			3'h5:    alu_r = {1'b0, a_ff & alu_b};
			3'h6:    alu_r = {1'b0, a_ff ^ alu_b};
			default: alu_r = {1'b0, a_ff} - {1'b0, alu_b};
		endcase
	end

	// pc leaves as the fetch address and as return bytes pushed to ram; lookups borrow the rom port
	assign rom_addr     = lk_ff ? lk_addr_ff : pc_ff;
	assign ram_addr     = ram_addr_ff;
	assign ram_wdata    = ram_wdata_ff;
	assign ram_we       = ram_we_ff;
	assign io_addr      = io_addr_ff;
	assign io_wdata     = io_wdata_ff;
	assign io_we        = io_we_ff;
	assign io_re        = io_re_ff;
	assign irq_ack      = irq_ack_ff;
	assign int_enable   = ie_ff;
	assign halted       = st_ff == ST_HALT;
	assign rom_reserved = rsv_ff;

	// ---------------------------------------------------------------
	// sequencer
	// ---------------------------------------------------------------
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			st_ff        <= ST_RUN;
			pc_ff        <= PC_RST;
			psp_ff       <= PSP_RST;
			dsp_ff       <= DSP_RST;
			ie_ff        <= 1'b0;
			{a_ff, x_ff, ir_ff, opnd_ff, tmp_ff} <= '0;
			{ram_addr_ff, ram_wdata_ff, io_addr_ff, io_wdata_ff} <= '0;
			{cyc_ff, vec_ff, lk_addr_ff} <= '0;
			{c_ff, z_ff, lk_ff, ram_we_ff, io_we_ff, io_re_ff, irq_ack_ff, rsv_ff} <= '0;
		end else begin
			ram_we_ff  <= 1'b0;
			io_we_ff   <= 1'b0;
			io_re_ff   <= 1'b0;
			irq_ack_ff <= 1'b0;
			cyc_ff     <= cyc_ff + 4'h1;
			case (st_ff)
				ST_HALT: cyc_ff <= 4'h0;
				ST_IRQ: begin
					if (cyc_ff == 4'h1) begin
						ram_addr_ff  <= psp_ff;
						ram_wdata_ff <= {c_ff, z_ff, pc_ff[13:8]};
						ram_we_ff    <= 1'b1;
						psp_ff       <= psp_ff + 8'h01;
						pc_ff        <= VEC_BASE + {9'h000, vec_ff, 1'b0};
					end
					if (cyc_ff == 4'(IRQ_CYCLES - 1)) begin
						st_ff  <= ST_RUN;
						cyc_ff <= 4'h0;
					end
				end
				ST_RUN: begin
					if (cyc_ff == 4'h0) begin
						if (irq_ok) begin
							st_ff        <= ST_IRQ;
							irq_ack_ff   <= 1'b1;
							vec_ff       <= irq_vec;
							ie_ff        <= 1'b0;
							ram_addr_ff  <= psp_ff;
							ram_wdata_ff <= pc_ff[7:0];
							ram_we_ff    <= 1'b1;
							psp_ff       <= psp_ff + 8'h01;
						end else begin
							ir_ff       <= rom_data;
							rsv_ff      <= pc_ff > PROG_END;
							pc_ff[7:0]  <= pc_ff[7:0] + 8'h01;
						end
					end else if (cyc_ff == 4'h1) begin
						if (two_byte) begin
							opnd_ff    <= rom_data;
							pc_ff[7:0] <= pc_ff[7:0] + 8'h01;
						end
						if (op_d || op_x) ram_addr_ff <= ea;
						if (op_i && op <= OP_CMP_I) begin
							if (!is_cmp) a_ff <= alu_r[7:0];
							c_ff <= alu_r[8];
							z_ff <= alu_r[7:0] == 8'h00;
						end
						if (is_call) begin
							ram_addr_ff  <= psp_ff;
							ram_wdata_ff <= pc_ff[7:0] + 8'h01;
							ram_we_ff    <= 1'b1;
							psp_ff       <= psp_ff + 8'h01;
						end
						if (op[7:4] >= NB_JMP && op[7:4] <= NB_JNC && br_ok) pc_ff <= br_tgt;
						if (op[7:4] == NB_JUMP_ACCUMULATOR_RELATIVE) pc_ff <= acc_tgt;
						if (op[7:4] == NB_INDEX) begin
							lk_addr_ff <= acc_tgt;
							lk_ff      <= 1'b1;
						end
						case (op)
							OP_MOVA_I: a_ff <= rom_data;
							OP_MOVX_I: x_ff <= rom_data;
							OP_PAGE_ADVANCE: pc_ff[13:8] <= pc_ff[13:8] + 6'h01;
							OP_INCA: {c_ff, a_ff} <= a_inc;
							OP_DECA: {c_ff, a_ff} <= a_dec;
							OP_INCX: x_ff <= x_ff + 8'h01;
							OP_DECX: x_ff <= x_ff - 8'h01;
							OP_IO_READ: begin
								io_addr_ff <= rom_data;
								io_re_ff   <= 1'b1;
							end
							OP_IO_WRITE, OP_IO_WRITE_INDEXED: begin
								io_addr_ff  <= ea;
								io_wdata_ff <= a_ff;
								io_we_ff    <= 1'b1;
							end
							OP_POPA, OP_POPX: begin
								ram_addr_ff <= dsp_ff;
								dsp_ff      <= dsp_ff + 8'h01;
							end
							OP_PUSHA, OP_PUSHX: begin
								dsp_ff       <= dsp_ff - 8'h01;
								ram_addr_ff  <= dsp_ff - 8'h01;
								ram_wdata_ff <= (op == OP_PUSHA) ? a_ff : x_ff;
								ram_we_ff    <= 1'b1;
							end
							OP_SWAPX: begin
								a_ff <= x_ff;
								x_ff <= a_ff;
							end
							OP_SWAPD: begin
								a_ff   <= dsp_ff;
								dsp_ff <= a_ff;
							end
							OP_STA_D, OP_STA_X: begin
								ram_wdata_ff <= a_ff;
								ram_we_ff    <= 1'b1;
							end
							OP_CPL: a_ff <= ~a_ff;
							OP_ASL: {c_ff, a_ff} <= {a_ff, 1'b0};
							OP_ASR: {a_ff, c_ff} <= {a_ff[7], a_ff};
							OP_RLC: {c_ff, a_ff} <= {a_ff, c_ff};
							OP_RRC: {a_ff, c_ff} <= {c_ff, a_ff};
							OP_RET, OP_RETI: begin
								psp_ff      <= psp_ff - 8'h01;
								ram_addr_ff <= psp_ff - 8'h01;
							end
							OP_MOVAX: a_ff <= x_ff;
							OP_MOVXA: x_ff <= a_ff;
							OP_MOVPSP: psp_ff <= a_ff;
							OP_DI: ie_ff <= 1'b0;
							OP_EI: ie_ff <= 1'b1;
							default: z_ff <= z_ff;
						endcase
					end else if (cyc_ff == 4'h2) begin
						if (op != OP_HALT && op <= OP_CMP_X && !op_i) begin
							if (!is_cmp) a_ff <= alu_r[7:0];
							c_ff <= alu_r[8];
							z_ff <= alu_r[7:0] == 8'h00;
						end
						if (is_call) begin
							ram_addr_ff  <= psp_ff;
							ram_wdata_ff <= {c_ff, z_ff, pc_ff[13:8]};
							ram_we_ff    <= 1'b1;
							psp_ff       <= psp_ff + 8'h01;
							pc_ff        <= call_tgt;
						end
						if (op[7:4] == NB_INDEX) begin
							a_ff  <= rom_data;
							lk_ff <= 1'b0;
						end
						case (op)
							OP_MOVA_D, OP_MOVA_X, OP_POPA: a_ff <= ram_rdata;
							OP_MOVX_D, OP_POPX: x_ff <= ram_rdata;
							OP_IO_READ: a_ff <= io_rdata;
							OP_INC_D, OP_INC_X: begin
								{c_ff, ram_wdata_ff} <= m_inc;
								ram_we_ff            <= 1'b1;
							end
							OP_DEC_D, OP_DEC_X: begin
								{c_ff, ram_wdata_ff} <= m_dec;
								ram_we_ff            <= 1'b1;
							end
							OP_OR_D, OP_OR_X, OP_AND_D, OP_AND_X, OP_XOR_D, OP_XOR_X: begin
								ram_wdata_ff <= rmw_val;
								z_ff         <= rmw_val == 8'h00;
								ram_we_ff    <= 1'b1;
							end
							OP_RET, OP_RETI: begin
								tmp_ff      <= ram_rdata;
								psp_ff      <= psp_ff - 8'h01;
								ram_addr_ff <= psp_ff - 8'h01;
							end
							default: z_ff <= z_ff;
						endcase
					end else if (cyc_ff == 4'h3 && (op == OP_RET || op == OP_RETI)) begin
						pc_ff <= {tmp_ff[5:0], ram_rdata};
						if (op == OP_RETI) begin
							{c_ff, z_ff} <= tmp_ff[7:6];
							ie_ff        <= 1'b1;
						end
					end
					if (cyc_ff != 4'h0 && last) begin
						cyc_ff <= 4'h0;
						if (op == OP_HALT) st_ff <= ST_HALT;
					end
				end
				default: st_ff <= ST_RUN;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	a_page_hold: assert property (@(posedge clk) disable iff (reset)
		(st_ff == ST_RUN && cyc_ff == 4'h0 && !irq_ok)
		|=> (pc_ff[13:8] == $past(pc_ff[13:8]) && pc_ff[7:0] == $past(pc_ff[7:0]) + 8'h01))
		else $error("fetch changed upper pc bits");
	a_irq_push: assert property (@(posedge clk) disable iff (reset)
		irq_take |=> (ram_we_ff && ram_addr_ff == $past(psp_ff) && !ie_ff)
		##1 (ram_we_ff && ram_addr_ff == $past(psp_ff, 2) + 8'h01))
		else $error("interrupt push order wrong");
	a_irq_vector: assert property (@(posedge clk) disable iff (reset)
		irq_take |-> ##2 (pc_ff >= VEC_BASE && pc_ff < USER_START && !pc_ff[0]))
		else $error("interrupt vector out of table");
	a_call_len: assert property (@(posedge clk) disable iff (reset)
		(run1 && is_call) |-> ##9 (cyc_ff == 4'h0 && psp_ff == $past(psp_ff, 9) + 8'h02))
		else $error("call length or stack step wrong");
	a_ret_flags: assert property (@(posedge clk) disable iff (reset)
		(run1 && op == OP_RET) |-> ##3 (psp_ff == $past(psp_ff, 3) - 8'h02 && c_ff == $past(c_ff, 3)))
		else $error("return changed flags or pointer");
	a_reti_ie: assert property (@(posedge clk) disable iff (reset)
		(run1 && op == OP_RETI) |-> ##3 (ie_ff && psp_ff == $past(psp_ff, 3) - 8'h02))
		else $error("interrupt return did not re-enable");
	a_psp_load: assert property (@(posedge clk) disable iff (reset)
		(run1 && op == OP_MOVPSP) |=> psp_ff == $past(a_ff))
		else $error("stack pointer load lost");
	a_push_dsp: assert property (@(posedge clk) disable iff (reset)
		(run1 && (op == OP_PUSHA || op == OP_PUSHX))
		|=> (dsp_ff == $past(dsp_ff) - 8'h01 && ram_we_ff && ram_addr_ff == dsp_ff))
		else $error("push not pre-decremented");
	a_halt_stay: assert property (@(posedge clk) disable iff (reset)
		st_ff == ST_HALT |=> (st_ff == ST_HALT && $stable(pc_ff)))
		else $error("left halt");
endmodule : mcs_core

// file: design/mcs_pkg.sv
// package: constants, vectors and opcode timing of the core sequencer
package mcs_pkg;
	localparam int          PC_W       = 14;
	localparam logic [13:0] PC_RST     = 14'h0000;
	localparam logic [13:0] PROG_END   = 14'h1FDF;
	localparam logic [13:0] VEC_BASE   = 14'h0002;
	localparam logic [13:0] USER_START = 14'h001A;
	localparam logic [3:0]  IRQ_RSVD   = 4'h8;
	localparam logic [3:0]  IRQ_LAST   = 4'hB;
	localparam logic [7:0]  PSP_RST    = 8'h00;
	localparam logic [7:0]  DSP_RST    = 8'h00;
	localparam int          IRQ_CYC    = 10;
	// ---------------------------------------------------------------
	// opcodes
	// ---------------------------------------------------------------
	localparam logic [7:0] OP_HALT = 8'h00, OP_ALU_END = 8'h15, OP_CMP_I = 8'h16, OP_CMP_D = 8'h17, OP_CMP_X = 8'h18;
	localparam logic [7:0] OP_MOVA_I = 8'h19, OP_MOVA_D = 8'h1A, OP_MOVA_X = 8'h1B, OP_MOVX_I = 8'h1C, OP_MOVX_D = 8'h1D;
	localparam logic [7:0] OP_PAGE_ADVANCE = 8'h1F, OP_INCA = 8'h21, OP_INCX = 8'h22, OP_INC_D = 8'h23, OP_INC_X = 8'h24;
	localparam logic [7:0] OP_DECA = 8'h25, OP_DECX = 8'h26, OP_DEC_D = 8'h27, OP_DEC_X = 8'h28;
	localparam logic [7:0] OP_IO_READ = 8'h29, OP_IO_WRITE = 8'h2A, OP_POPA = 8'h2B, OP_POPX = 8'h2C, OP_PUSHA = 8'h2D;
	localparam logic [7:0] OP_PUSHX = 8'h2E, OP_SWAPX = 8'h2F, OP_SWAPD = 8'h30, OP_STA_D = 8'h31, OP_STA_X = 8'h32;
	localparam logic [7:0] OP_OR_D = 8'h33, OP_OR_X = 8'h34, OP_AND_D = 8'h35, OP_AND_X = 8'h36, OP_XOR_D = 8'h37;
	localparam logic [7:0] OP_XOR_X = 8'h38, OP_IO_WRITE_INDEXED = 8'h39, OP_CPL = 8'h3A, OP_ASL = 8'h3B, OP_ASR = 8'h3C;
	localparam logic [7:0] OP_RLC = 8'h3D, OP_RRC = 8'h3E, OP_RET = 8'h3F, OP_MOVAX = 8'h40, OP_MOVXA = 8'h41;
	localparam logic [7:0] OP_MOVPSP = 8'h60, OP_DI = 8'h70, OP_EI = 8'h72, OP_RETI = 8'h73;
	localparam logic [3:0] NB_CALL0 = 4'h5, NB_JMP = 4'h8, NB_CALL1 = 4'h9, NB_JZ = 4'hA, NB_JNZ = 4'hB;
	localparam logic [3:0] NB_JC = 4'hC, NB_JNC = 4'hD, NB_JUMP_ACCUMULATOR_RELATIVE = 4'hE, NB_INDEX = 4'hF;

	typedef enum logic [1:0] {ST_RUN = 2'b00, ST_IRQ = 2'b01, ST_HALT = 2'b10} mcs_state_t;

	function automatic logic is_imm(input logic [7:0] op);
		return op inside {8'h01, 8'h04, 8'h07, 8'h0A, 8'h0D, 8'h10, 8'h13, OP_CMP_I, OP_MOVA_I, OP_MOVX_I};
	endfunction : is_imm

	function automatic logic is_dir(input logic [7:0] op);
		return op inside {8'h02, 8'h05, 8'h08, 8'h0B, 8'h0E, 8'h11, 8'h14, OP_CMP_D, OP_MOVA_D, OP_MOVX_D,
			OP_INC_D, OP_DEC_D, OP_IO_READ, OP_IO_WRITE, OP_STA_D, OP_OR_D, OP_AND_D, OP_XOR_D};
	endfunction : is_dir

	function automatic logic is_idx(input logic [7:0] op);
		return op inside {8'h03, 8'h06, 8'h09, 8'h0C, 8'h0F, 8'h12, OP_ALU_END, OP_CMP_X, OP_MOVA_X,
			OP_INC_X, OP_DEC_X, OP_STA_X, OP_OR_X, OP_AND_X, OP_XOR_X, OP_IO_WRITE_INDEXED};
	endfunction : is_idx

	// unlisted and reserved opcodes cost 4 cycles like a no-operation
	function automatic logic [3:0] op_cycles(input logic [7:0] op);
		logic [3:0] n;
		n = 4'h4;
		if (op == OP_HALT) n = 4'h7;
		else if (op <= OP_ALU_END) n = is_idx(op) ? 4'h7 : (is_dir(op) ? 4'h6 : 4'h4);
		else if (op == OP_CMP_I) n = 4'h5;
		else if (op == OP_CMP_D) n = 4'h7;
		else if (op == OP_CMP_X) n = 4'h8;
		else if (op inside {OP_MOVA_D, OP_MOVX_D, OP_IO_READ, OP_IO_WRITE, OP_PUSHA, OP_PUSHX, OP_SWAPX, OP_SWAPD,
			OP_STA_D}) n = 4'h5;
		else if (op inside {OP_MOVA_X, OP_IO_WRITE_INDEXED, OP_STA_X}) n = 4'h6;
		else if (op inside {OP_INC_D, OP_DEC_D, OP_OR_D, OP_AND_D, OP_XOR_D}) n = 4'h7;
		else if (op inside {OP_INC_X, OP_DEC_X, OP_OR_X, OP_AND_X, OP_XOR_X, OP_RET, OP_RETI}) n = 4'h8;
		else if (op[7:4] == NB_CALL0 || op[7:4] == NB_CALL1) n = 4'hA;
		else if (op[7:4] == NB_JUMP_ACCUMULATOR_RELATIVE) n = 4'h7;
		else if (op[7:4] == NB_INDEX) n = 4'hE;
		else if (op[7:4] >= NB_JMP) n = 4'h5;
		return n;
	endfunction : op_cycles
endpackage : mcs_pkg

// file: tb/mcs_mem_model.sv
// memory model: program rom, data ram and io answer facing the core sequencer
module mcs_mem_model (
	input  wire logic        clk,
	input  wire logic [13:0] rom_addr,
	output wire logic [7:0]  rom_data,
	input  wire logic [7:0]  ram_addr,
	input  wire logic [7:0]  ram_wdata,
	input  wire logic        ram_we,
	output wire logic [7:0]  ram_rdata,
	input  wire logic        io_re,
	output wire logic [7:0]  io_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] rom [0:16383];
	logic [7:0] ram [0:255];          // stack bytes sit here, visible as plain data
	logic [7:0] last_waddr;
	// ---------------------------------------------------------------
	// asynchronous reads, write on the strobed edge
	// ---------------------------------------------------------------
	assign rom_data  = rom[rom_addr];
	assign ram_rdata = ram[ram_addr];
	// answer only while the read strobe stands; otherwise wiggle so a stale sample shows
	assign io_rdata  = io_re ? 8'h5A : {8{clk}};
	always @(posedge clk) begin
		if (ram_we === 1'b1) begin
			ram[ram_addr] <= ram_wdata;
			last_waddr    <= ram_addr;
		end
	end
endmodule : mcs_mem_model

// file: tb/testbench.sv
// self-checking bench: small programs run from the memory model, fetch trace and stack bytes compared
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk, reset, irq_req, irq_ack, int_enable, halted, ram_we, io_re, io_we, rom_reserved;
	logic [13:0] rom_addr;
	logic [7:0]  rom_data, ram_addr, ram_wdata, ram_rdata, io_rdata, io_addr, io_wdata;
	logic [15:0] io_last;
	logic [3:0]  irq_vec;
	bit          seen [0:16383];
	int          miscompares, checks_done, acks, cyc, t, t_ref;
	// opcode, operand, cycles; targets and fall-through all land on halt filler
	logic [23:0] tt [$] = '{24'h1610_05, 24'h1710_07, 24'h1810_08, 24'h1910_04, 24'h1A10_05, 24'h1B10_06,
		24'h1C10_04, 24'h1D10_05, 24'h1E00_04, 24'h1F00_04, 24'h2100_04, 24'h2200_04, 24'h2310_07,
		24'h2410_08, 24'h2500_04, 24'h2600_04, 24'h2710_07, 24'h2810_08, 24'h2910_05, 24'h2A10_05,
		24'h2B00_04, 24'h2C00_04, 24'h2D00_05, 24'h2E00_05, 24'h2F00_05, 24'h3000_05, 24'h3110_05,
		24'h3210_06, 24'h3310_07, 24'h3410_08, 24'h3510_07, 24'h3610_08, 24'h3710_07, 24'h3810_08,
		24'h3910_06, 24'h3A00_04, 24'h3B00_04, 24'h3C00_04, 24'h3D00_04, 24'h3E00_04, 24'h3F00_08,
		24'h4000_04, 24'h4100_04, 24'h6000_04, 24'h7000_04, 24'h7200_04, 24'h7300_08, 24'h5010_0A,
		24'h9010_0A, 24'h8010_05, 24'hA010_05, 24'hB010_05, 24'hC010_05, 24'hD010_05, 24'hE010_07,
		24'hF010_0E};

	mcs_core DUT (.clk(clk), .reset(reset), .rom_addr(rom_addr), .rom_data(rom_data), .ram_addr(ram_addr),
		.ram_wdata(ram_wdata), .ram_we(ram_we), .ram_rdata(ram_rdata), .io_addr(io_addr), .io_wdata(io_wdata),
		.io_we(io_we), .io_re(io_re), .io_rdata(io_rdata), .irq_req(irq_req), .irq_vec(irq_vec),
		.irq_ack(irq_ack), .int_enable(int_enable), .halted(halted), .rom_reserved(rom_reserved));
	mcs_mem_model mem (.clk(clk), .rom_addr(rom_addr), .rom_data(rom_data), .ram_addr(ram_addr),
		.ram_wdata(ram_wdata), .ram_we(ram_we), .ram_rdata(ram_rdata), .io_re(io_re), .io_rdata(io_rdata));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// ---------------------------------------------------------------
	// monitors: fetch trace, acknowledge count, hang limit
	// ---------------------------------------------------------------
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (reset === 1'b0) seen[rom_addr] <= 1'b1;
		if (io_we === 1'b1) io_last <= {io_addr, io_wdata};
		if (irq_ack === 1'b1) begin
			acks    <= acks + 1;
			irq_req <= 1'b0;
		end
		if (cyc == 30000) begin
			miscompares++;
			final_report();
		end
	end

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check

	// reset, refill rom with halt, load first four bytes, release
	task automatic start(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2, input logic [7:0] b3);
		reset <= 1'b1;
		@(posedge clk);
		for (int i = 0; i < 16384; i++) begin
			mem.rom[i] = 8'h00;
			seen[i] = 1'b0;
		end
		mem.rom[0] = b0;
		mem.rom[1] = b1;
		mem.rom[2] = b2;
		mem.rom[3] = b3;
		mem.ram[8'hFE] = 8'h10;  // stray return lands on halt filler
		mem.ram[8'hFF] = 8'h00;
		repeat (3) @(posedge clk);
		check(16'(rom_addr), 16'h0000);
		reset <= 1'b0;
	endtask : start

	task automatic run(output int n);
		n = 0;
		while (halted !== 1'b1 && n < 400) begin
			@(posedge clk);
			n++;
		end
	endtask : run

	task automatic final_report;
		$display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : final_report

	initial begin
		reset = 1'b1;
		irq_req = 1'b0;
		irq_vec = 4'h0;
		miscompares = 0;
		checks_done = 0;
		acks = 0;
		cyc = 0;
		// ---------------------------------------------------------------
		// cycle counts, measured against a no-operation reference
		// ---------------------------------------------------------------
		start(8'h20, 8'h00, 8'h00, 8'h00);
		run(t_ref);
		check(16'(seen[0]), 16'h0001);
		start(8'h00, 8'h00, 8'h00, 8'h00);
		run(t);
		check(16'(t_ref - t), 16'h0004);
		for (int g = 0; g < 7; g++) begin
			for (int m = 0; m < 3; m++) begin
				start(8'(1 + 3 * g + m), 8'h10, 8'h00, 8'h00);
				run(t);
				check(16'(t - t_ref + 4), m == 0 ? 16'h0004 : 16'h0005 + 16'(m));
			end
		end
		foreach (tt[i]) begin
			start(tt[i][23:16], tt[i][15:8], 8'h00, 8'h00);
			run(t);
			check(16'(t - t_ref + 4), {8'h00, tt[i][7:0]});
		end
		// ---------------------------------------------------------------
		// call, return, second call lands on the same stack slot
		// ---------------------------------------------------------------
		start(8'h53, 8'h45, 8'h55, 8'h67);
		mem.rom[14'h345] = 8'h3F;
		run(t);
		check(16'({seen[14'h345], seen[14'h002], seen[14'h567]}), 16'h0007);
		check(16'(mem.ram[0]), 16'h0004);
		check(16'(mem.ram[1][5:0]), 16'h0000);
		// ---------------------------------------------------------------
		// low byte wraps inside the page; page_advance moves on
		// ---------------------------------------------------------------
		start(8'h81, 8'hFE, 8'h00, 8'h00);
		mem.rom[14'h100] = 8'h81; // an opcode fetched at 0x100 jumps on to 0x180
		mem.rom[14'h101] = 8'h80;
		mem.rom[14'h1FE] = 8'h20;
		mem.rom[14'h1FF] = 8'h20;
		run(t);
		check(16'({seen[14'h180], seen[14'h200]}), 16'h0002);
		check(16'(rom_reserved), 16'h0000);
		start(8'h81, 8'hFE, 8'h00, 8'h00);
		mem.rom[14'h100] = 8'h81;
		mem.rom[14'h101] = 8'h80;
		mem.rom[14'h1FE] = 8'h20;
		mem.rom[14'h1FF] = 8'h1F;
		run(t);
		check(16'({seen[14'h180], seen[14'h200]}), 16'h0001);
		// sixteen page steps along a diagonal land past the usable end
		start(8'h8F, 8'hFF, 8'h00, 8'h00);
		mem.rom[14'h0FFF] = 8'h1F;
		for (int k = 0; k < 16; k++) begin
			mem.rom[14'h1000 + 14'(k) * 14'h0101] = 8'h1F;
		end
		run(t);
		check(16'({seen[14'h2010], rom_reserved}), 16'h0003);
		// io read answer carried through the accumulator to an io write
		start(8'h29, 8'h07, 8'h2A, 8'h33);
		run(t);
		check(io_last, 16'h335A);
		// ---------------------------------------------------------------
		// data stack wrap and indexed store address
		// ---------------------------------------------------------------
		start(8'h2D, 8'h00, 8'h00, 8'h00);
		run(t);
		check(16'(mem.last_waddr), 16'h00FF);
		start(8'h1C, 8'h05, 8'h32, 8'h10);
		run(t);
		check(16'(mem.last_waddr), 16'h0015);
		// ---------------------------------------------------------------
		// every vector; the reserved one is ignored, gpio returns
		// ---------------------------------------------------------------
		for (int v = 0; v < 12; v++) begin
			start(8'h80, 8'h30, 8'h00, 8'h00);
			mem.rom[14'h030] = 8'h72;
			mem.rom[14'h031] = 8'h80;
			mem.rom[14'h032] = 8'h31;
			mem.rom[14'h016] = 8'h73;
			acks = 0;
			irq_vec <= 4'(v);
			irq_req <= 1'b1;
			run(t);
			irq_req <= 1'b0;
			check(16'(seen[14'(2 + 2 * v)]), v == 8 ? 16'h0000 : 16'h0001);
			check(16'(acks), v == 8 ? 16'h0000 : 16'h0001);
			check(16'(int_enable), (v == 8 || v == 10) ? 16'h0001 : 16'h0000);
			if (v == 10) begin
				check(16'(mem.ram[0]), 16'h0031);
				check(16'(halted), 16'h0000);
			end
		end
		final_report();
	end
endmodule : testbench
